// ### logic/setting_area_exchange.sv
// Purpose: Word exchange between a four-channel input module and its controller.
// Assumes: refresh_i is a one-cycle pulse per cyclic refresh; inputs are synchronous.
// Notes: Settings live in flip-flops behind a classic Wishbone slave.
// Notes on behaviour
// - Four channels, each with its own independently applied input type.
// - Operating words (values, alarms, sensor errors) captured every refresh.
// - Defaults delivered on read command only at start.
// - Continuous settings taken every refresh and at power-on or restart.
// - Initial settings read only at power-on or restart.
// - Expansion settings read only at power-on or restart.
// - Out-of-range continuous or initial word lights the setting error lamp.
// - Error-address word holds offset of first bad word from base.
// - Bad expansion word reports offset 100 or above.
// - Continuous errors reported at once; initial ones again after restart.
// - Operating and setting words placed by unit number.
// - Operating base 2000 plus 10N; setting base 20000 plus 100N.
//
// The address map and register access over Wishbone were left to the implementer.
module setting_area_exchange (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic refresh_i,
    input wire logic restart_i,
    input wire logic [6:0] unit_no_i,
    input wire logic [63:0] pv_i,
    input wire logic [15:0] alarm_i,
    input wire logic [3:0] sensor_err_i,
    output logic [255:0] cont_act_o,
    output logic [127:0] init_act_o,
    output logic [63:0] exp_act_o,
    output logic [15:0] io_base_o,
    output logic [15:0] set_base_o,
    output logic setting_error_lamp_o,
    output logic irq_o
);

    // ---------------------------------------------------------------------
    // State
    // ---------------------------------------------------------------------
    typedef struct packed {
        setting_area_pkg::phase_t phase;
        logic restart;
        logic [15:0] cmd;
        logic [15:0] err_addr;

        logic [setting_area_pkg::CONT_WORDS-1:0][15:0] cont;
        logic [setting_area_pkg::CONT_WORDS-1:0][15:0] cont_act;
        logic [setting_area_pkg::INIT_WORDS-1:0][15:0] init;
        logic [setting_area_pkg::INIT_WORDS-1:0][15:0] init_act;
        logic [setting_area_pkg::EXP_WORDS-1:0][15:0] expn;
        logic [setting_area_pkg::EXP_WORDS-1:0][15:0] expn_act;

        logic [setting_area_pkg::OP_WORDS-1:0][15:0] op;

        logic init_err;
        logic [15:0] init_err_addr;
        logic lamp;

        logic [setting_area_pkg::IRQ_BITS-1:0] sts;
        logic [setting_area_pkg::IRQ_BITS-1:0] ena;
        logic irq;

        logic ack;
        logic [31:0] rdat;
        logic [15:0] io_base;
        logic [15:0] set_base;
    } state_t;

    state_t q;
    state_t d;

    // ---------------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
        merge16 = old;
        if (sel[0]) begin
            merge16[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = dat[15:8];
        end
    endfunction : merge16

    // Word k of a channel: 0 hysteresis, 1 on-delay, 2 zero, 3 span
    function automatic logic cont_ok(input int k, input logic [15:0] v);
        unique case (k % setting_area_pkg::CONT_PER_CH)
            0: cont_ok = v <= setting_area_pkg::HYST_MAX;
            1: cont_ok = v <= setting_area_pkg::DELAY_MAX;
            default: cont_ok = ($signed(v) <= setting_area_pkg::ADJ_MAX)
                && ($signed(v) >= -setting_area_pkg::ADJ_MAX);
        endcase
    endfunction : cont_ok

    // Word 0 of a channel is its input type, word 1 its scaling
    function automatic logic init_ok(input int k, input logic [15:0] v);
        init_ok = (k % setting_area_pkg::INIT_PER_CH != 0) || setting_area_pkg::type_ok(v);
    endfunction : init_ok

    // ---------------------------------------------------------------------
    // Range scan: first bad word of each group, lowest offset wins
    // ---------------------------------------------------------------------
    logic cont_bad;
    logic [15:0] cont_off;

    logic init_bad;
    logic [15:0] init_off;

    logic exp_bad;
    logic [15:0] exp_off;

    always_comb begin
        cont_bad = 1'b0;
        cont_off = setting_area_pkg::NO_ERROR;
        init_bad = 1'b0;
        init_off = setting_area_pkg::NO_ERROR;
        exp_bad = 1'b0;
        exp_off = setting_area_pkg::NO_ERROR;

        for (int i = setting_area_pkg::CONT_WORDS - 1; i >= 0; i--) begin
            if (!cont_ok(i, q.cont[i])) begin
                cont_bad = 1'b1;
                cont_off = {8'h00, setting_area_pkg::IDX_CONT + 8'(i)};
            end
        end

        for (int i = setting_area_pkg::INIT_WORDS - 1; i >= 0; i--) begin
            if (!init_ok(i, q.init[i])) begin
                init_bad = 1'b1;
                init_off = {8'h00, setting_area_pkg::IDX_INIT + 8'(i)};
            end
        end

        for (int i = setting_area_pkg::EXP_WORDS - 1; i >= 0; i--) begin
            if (q.expn[i] > setting_area_pkg::EXP_MAX) begin
                exp_bad = 1'b1;
                exp_off = {8'h00, setting_area_pkg::IDX_EXP + 8'(i)};
            end
        end
    end

    // ---------------------------------------------------------------------
    // Register read mux
    // ---------------------------------------------------------------------
    // Clear and unmapped words read as zero
    function automatic logic [15:0] read_word(input state_t s, input logic [7:0] idx);
        read_word = 16'h0000;
        if (idx == setting_area_pkg::IDX_CMD) begin
            read_word = s.cmd;
        end else if (idx == setting_area_pkg::IDX_ERR_ADDR) begin
            read_word = s.err_addr;
        end else if (idx >= setting_area_pkg::IDX_CONT && idx < setting_area_pkg::IDX_INIT) begin
            read_word = s.cont[4'(idx - setting_area_pkg::IDX_CONT)];
        end else if (idx >= setting_area_pkg::IDX_INIT
                     && idx < setting_area_pkg::IDX_INIT + 8'(setting_area_pkg::INIT_WORDS)) begin
            read_word = s.init[3'(idx - setting_area_pkg::IDX_INIT)];
        end else if (idx >= setting_area_pkg::IDX_EXP
                     && idx < setting_area_pkg::IDX_EXP + 8'(setting_area_pkg::EXP_WORDS)) begin
            read_word = s.expn[2'(idx - setting_area_pkg::IDX_EXP)];
        end else if (idx >= setting_area_pkg::IDX_OP
                     && idx < setting_area_pkg::IDX_OP + 8'(setting_area_pkg::OP_WORDS)) begin
            read_word = s.op[4'(idx - setting_area_pkg::IDX_OP)];
        end else if (idx == setting_area_pkg::IDX_STATUS) begin
            read_word = {13'h0000, s.sts};
        end else if (idx == setting_area_pkg::IDX_ENABLE) begin
            read_word = {13'h0000, s.ena};
        end
    endfunction : read_word

    // ---------------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------------
    logic [7:0] idx;
    logic [setting_area_pkg::IRQ_BITS-1:0] ev;
    logic [setting_area_pkg::IRQ_BITS-1:0] clr;

    always_comb begin
        d = q;
        d.ack = 1'b0;
        idx = wb_adr_i;
        ev = '0;
        clr = '0;

        // Ack one cycle after the take
        if (wb_cyc_i && wb_stb_i && !q.ack) begin
            d.ack = 1'b1;
            d.rdat = {16'h0000, read_word(q, idx)};

            if (wb_we_i) begin
                if (idx == setting_area_pkg::IDX_CMD) begin
                    d.cmd = merge16(q.cmd, wb_dat_i, wb_sel_i);
                end else if (idx >= setting_area_pkg::IDX_CONT
                             && idx < setting_area_pkg::IDX_INIT) begin
                    d.cont[4'(idx - setting_area_pkg::IDX_CONT)] =
                        merge16(q.cont[4'(idx - setting_area_pkg::IDX_CONT)], wb_dat_i, wb_sel_i);
                end else if (idx >= setting_area_pkg::IDX_INIT
                             && idx < setting_area_pkg::IDX_INIT
                                      + 8'(setting_area_pkg::INIT_WORDS)) begin
                    // Stored now, applied only at the next start
                    d.init[3'(idx - setting_area_pkg::IDX_INIT)] =
                        merge16(q.init[3'(idx - setting_area_pkg::IDX_INIT)], wb_dat_i, wb_sel_i);
                end else if (idx >= setting_area_pkg::IDX_EXP
                             && idx < setting_area_pkg::IDX_EXP
                                      + 8'(setting_area_pkg::EXP_WORDS)) begin
                    d.expn[2'(idx - setting_area_pkg::IDX_EXP)] =
                        merge16(q.expn[2'(idx - setting_area_pkg::IDX_EXP)], wb_dat_i, wb_sel_i);
                end else if (idx == setting_area_pkg::IDX_CLEAR && wb_sel_i[0]) begin
                    clr = wb_dat_i[setting_area_pkg::IRQ_BITS-1:0];
                end else if (idx == setting_area_pkg::IDX_ENABLE && wb_sel_i[0]) begin
                    d.ena = wb_dat_i[setting_area_pkg::IRQ_BITS-1:0];
                end
            end
        end

        // Restart bit: hold while set, start over when it is cleared
        d.restart = restart_i;
        unique case (q.phase)
            setting_area_pkg::PH_INIT: begin
                if (q.cmd == setting_area_pkg::DEFAULT_CMD) begin
                    // Defaults overwrite stored words for read back
                    for (int i = 0; i < setting_area_pkg::CONT_WORDS; i++) begin
                        d.cont[i] = setting_area_pkg::CONT_DEFAULT;
                    end
                    for (int i = 0; i < setting_area_pkg::INIT_WORDS; i++) begin
                        d.init[i] = (i % setting_area_pkg::INIT_PER_CH == 0)
                            ? setting_area_pkg::TYPE_DEFAULT : setting_area_pkg::SCALE_DEFAULT;
                    end
                    for (int i = 0; i < setting_area_pkg::EXP_WORDS; i++) begin
                        d.expn[i] = setting_area_pkg::EXP_DEFAULT;
                    end
                    d.cmd = 16'h0000;
                    d.init_err = 1'b0;
                    d.err_addr = setting_area_pkg::NO_ERROR;
                    d.lamp = 1'b0;
                end else begin
                    d.init_err = init_bad || exp_bad;
                    d.lamp = cont_bad || init_bad || exp_bad;
                    if (cont_bad) begin
                        d.err_addr = cont_off;
                    end else if (init_bad) begin
                        d.err_addr = init_off;
                    end else if (exp_bad) begin
                        d.err_addr = exp_off;
                    end else begin
                        d.err_addr = setting_area_pkg::NO_ERROR;
                    end
                    ev[setting_area_pkg::IRQ_RANGE] = d.lamp;
                end

                d.init_err_addr = init_bad ? init_off : exp_off;
                d.cont_act = d.cont;
                d.init_act = d.init;
                d.expn_act = d.expn;

                // Unit number sampled at each start
                d.io_base = setting_area_pkg::IO_BASE
                    + 16'(unit_no_i) * setting_area_pkg::IO_SPAN;
                d.set_base = setting_area_pkg::SET_BASE
                    + 16'(unit_no_i) * setting_area_pkg::SET_SPAN;

                ev[setting_area_pkg::IRQ_INIT] = 1'b1;
                d.phase = restart_i ? setting_area_pkg::PH_HOLD : setting_area_pkg::PH_RUN;
            end

            setting_area_pkg::PH_RUN: begin
                if (restart_i) begin
                    d.phase = setting_area_pkg::PH_HOLD;
                end else if (refresh_i) begin
                    for (int c = 0; c < setting_area_pkg::CHANNELS; c++) begin
                        d.op[c] = pv_i[c*16 +: 16];
                    end
                    d.op[setting_area_pkg::CHANNELS] = alarm_i;
                    d.op[setting_area_pkg::CHANNELS+1] = {12'h000, sensor_err_i};

                    d.cont_act = q.cont;
                    // Initial-group error stays latched until the next start
                    if (cont_bad) begin
                        d.err_addr = cont_off;
                    end else if (q.init_err) begin
                        d.err_addr = q.init_err_addr;
                    end else begin
                        d.err_addr = setting_area_pkg::NO_ERROR;
                    end

                    d.lamp = cont_bad || q.init_err;
                    ev[setting_area_pkg::IRQ_RANGE] = cont_bad && !q.lamp;
                    ev[setting_area_pkg::IRQ_REFRESH] = 1'b1;
                end
            end

            // Refresh is refused while held
            setting_area_pkg::PH_HOLD: begin
                if (q.restart && !restart_i) begin
                    d.phase = setting_area_pkg::PH_INIT;
                end
            end
        endcase

        // Set wins over a clear in the same cycle
        d.sts = (q.sts & ~clr) | ev;
        d.irq = |(d.sts & d.ena);
    end

    // ---------------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            q.phase <= setting_area_pkg::PH_INIT;

            for (int i = 0; i < setting_area_pkg::INIT_WORDS; i++) begin
                q.init[i] <= (i % setting_area_pkg::INIT_PER_CH == 0)
                    ? setting_area_pkg::TYPE_DEFAULT : setting_area_pkg::SCALE_DEFAULT;
            end
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------------
    assign wb_dat_o = q.rdat;
    assign wb_ack_o = q.ack;

    assign cont_act_o = q.cont_act;
    assign init_act_o = q.init_act;
    assign exp_act_o = q.expn_act;
    assign io_base_o = q.io_base;
    assign set_base_o = q.set_base;
    assign setting_error_lamp_o = q.lamp;
    assign irq_o = q.irq;

endmodule : setting_area_exchange

// ### logic/setting_area_pkg.sv
// Purpose: Shared constants and types.
// Assumes: Registers are 16-bit words, one per aligned 32-bit Wishbone word.
// Notes: Byte address is four times the word index.
package setting_area_pkg;

    // ---------------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------------
    localparam int CHANNELS = 4;
    localparam int CONT_PER_CH = 4;
    localparam int INIT_PER_CH = 2;
    localparam int CONT_WORDS = CHANNELS * CONT_PER_CH;
    localparam int INIT_WORDS = CHANNELS * INIT_PER_CH;
    localparam int EXP_WORDS = 4;
    localparam int OP_WORDS = 10;

    // ---------------------------------------------------------------------
    // Word indices
    // ---------------------------------------------------------------------
    localparam logic [7:0] IDX_CMD = 8'h00;
    localparam logic [7:0] IDX_ERR_ADDR = 8'h01;
    localparam logic [7:0] IDX_CONT = 8'h02;
    localparam logic [7:0] IDX_INIT = 8'h12;
    localparam logic [7:0] IDX_EXP = 8'h64;
    localparam logic [7:0] IDX_OP = 8'h80;
    localparam logic [7:0] IDX_STATUS = 8'h8c;
    localparam logic [7:0] IDX_CLEAR = 8'h8d;
    localparam logic [7:0] IDX_ENABLE = 8'h8e;

    // ---------------------------------------------------------------------
    // Host memory placement
    // ---------------------------------------------------------------------
    localparam logic [15:0] IO_BASE = 16'h07d0;
    localparam logic [15:0] IO_SPAN = 16'h000a;
    localparam logic [15:0] SET_BASE = 16'h4e20;
    localparam logic [15:0] SET_SPAN = 16'h0064;

    // ---------------------------------------------------------------------
    // Values and limits
    // ---------------------------------------------------------------------
    localparam logic [15:0] DEFAULT_CMD = 16'h0001;
    localparam logic [15:0] CONT_DEFAULT = 16'h0000;
    localparam logic [15:0] TYPE_DEFAULT = 16'h0015;
    localparam logic [15:0] SCALE_DEFAULT = 16'h0000;
    localparam logic [15:0] EXP_DEFAULT = 16'h0000;
    localparam logic [15:0] HYST_MAX = 16'h270f;
    localparam logic [15:0] DELAY_MAX = 16'h003c;
    localparam logic signed [15:0] ADJ_MAX = 16'sh270f;
    localparam logic [15:0] EXP_MAX = 16'h0001;
    localparam logic [15:0] NO_ERROR = 16'h0000;

    // Interrupt status bits
    localparam int IRQ_RANGE = 0;
    localparam int IRQ_REFRESH = 1;
    localparam int IRQ_INIT = 2;
    localparam int IRQ_BITS = 3;

    typedef enum logic [1:0] {PH_INIT, PH_RUN, PH_HOLD} phase_t;

    // Input type codes accepted by a channel
    function automatic logic type_ok(input logic [15:0] v);
        unique case (v)
            16'h0000, 16'h0003, 16'h0007, 16'h0015, 16'h0017, 16'h0019, 16'h0021,
            16'h0024, 16'h0025, 16'h0026, 16'h0030, 16'h0031, 16'h0032, 16'h0035,
            16'h0036: type_ok = 1'b1;
            default: type_ok = 1'b0;
        endcase
    endfunction : type_ok

endpackage : setting_area_pkg

// ### tb/host_refresh_model.sv
// Purpose: Controller side: refresh pulse, restart bit, process data.
// Assumes: One clock shared with the exchange block.
// Notes: Data moves only with a refresh pulse.
module host_refresh_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic kick_i,
    output logic refresh_o,
    output logic restart_o,
    output logic [63:0] pv_o,
    output logic [15:0] alarm_o,
    output logic [3:0] sensor_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_q;
    logic [1:0] hold_q;
    logic [15:0] seed_q;
    assign pv_o = {seed_q, ~seed_q, seed_q ^ 16'h00ff, seed_q + 16'h0011};
    assign alarm_o = seed_q ^ 16'h5a5a;
    assign sensor_o = seed_q[3:0];
    assign restart_o = hold_q != 2'h0;
    // ------------------------------------------------------------------
    // Refresh cadence and restart bit
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 2'h0;
            hold_q <= 2'h0;
            seed_q <= 16'h1234;
            refresh_o <= 1'b0;
        end else begin
            cnt_q <= run_i ? cnt_q + 2'h1 : 2'h0;
            refresh_o <= run_i && cnt_q == 2'h3;
            if (run_i && cnt_q == 2'h3) begin
                seed_q <= seed_q + 16'h0101;
            end
            // Set, hold three cycles, clear
            if (kick_i) begin
                hold_q <= 2'h3;
            end else if (hold_q != 2'h0) begin
                hold_q <= hold_q - 2'h1;
            end
        end
    end
endmodule : host_refresh_model

// ### tb/setting_area_asserts.sv
// Purpose: Port-level timing checks.
// Assumes: restart_i is held high for at least two cycles.
// Notes: Init edges are found from restart_i and rst_i history.
module setting_area_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic refresh_i,
    input wire logic restart_i,
    input wire logic [6:0] unit_no_i,
    input wire logic [255:0] cont_act_o,
    input wire logic [127:0] init_act_o,
    input wire logic [63:0] exp_act_o,
    input wire logic [15:0] io_base_o,
    input wire logic [15:0] set_base_o,
    input wire logic setting_error_lamp_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // Edge after an init ran
    sequence init_s;
        ($past(restart_i, 3) && !$past(restart_i, 2)) || $past(rst_i, 2);
    endsequence
    sequence held_s;
        restart_i [*2];
    endsequence

    AST_ACK_ONE:
    assert property (take_s |=> ack_s) else $error("ack not one pulse");
    AST_NO_STRAY_ACK:
    assert property (!wb_stb_i |=> !wb_ack_o) else $error("ack without a request");
    AST_IO_BASE:
    assert property ($fell(restart_i) |-> ##2 io_base_o ==
        16'(setting_area_pkg::IO_BASE + setting_area_pkg::IO_SPAN * unit_no_i))
        else $error("operating base wrong");
    AST_SET_BASE:
    assert property ($fell(restart_i) |-> ##2 set_base_o ==
        16'(setting_area_pkg::SET_BASE + setting_area_pkg::SET_SPAN * unit_no_i))
        else $error("setting base wrong");
    AST_INIT_STILL:
    assert property ($changed(init_act_o) |-> init_s) else $error("initial settings moved");
    AST_EXP_STILL:
    assert property ($changed(exp_act_o) |-> init_s) else $error("expansion settings moved");
    AST_CONT_CAUSE:
    assert property ($changed(cont_act_o) |-> $past(refresh_i) or init_s)
        else $error("continuous settings moved");
    AST_LAMP_CAUSE:
    assert property ($changed(setting_error_lamp_o) |-> $past(refresh_i) or init_s)
        else $error("lamp moved");
    AST_HOLD_FREEZE:
    assert property (held_s |=> $stable(cont_act_o) && $stable(setting_error_lamp_o))
        else $error("outputs moved in hold");
endmodule : setting_area_asserts

bind setting_area_exchange setting_area_asserts i_chk (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .refresh_i, .restart_i, .unit_no_i, .cont_act_o, .init_act_o,
    .exp_act_o, .io_base_o, .set_base_o, .setting_error_lamp_o);

// ### tb/setting_area_exchange_test.sv
// Purpose: Self-checking bench.
// Assumes: One Wishbone access at a time.
// Notes: Expected values come from package constants, literals and host model outputs.
module setting_area_exchange_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] UNIT = 7'h05;
    localparam logic [15:0] IO_EXP = setting_area_pkg::IO_BASE + 16'h000a * 16'(UNIT);
    localparam logic [15:0] SET_EXP = setting_area_pkg::SET_BASE + 16'h0064 * 16'(UNIT);
    localparam logic [15:0] TDEF = setting_area_pkg::TYPE_DEFAULT;
    localparam logic [15:0] DMAX = setting_area_pkg::DELAY_MAX;
    logic clk_i, rst_i, cyc, stb, we, ack, refresh, restart, lamp, irq, run, kick;
    logic [7:0] adr;
    logic [31:0] dat, rdo;
    logic [15:0] rdat, alarm, io_base, set_base;
    logic [63:0] pv, expw;
    logic [3:0] sens;
    logic [255:0] cont;
    logic [127:0] init;
    int error_cnt, comparisons;

    setting_area_exchange i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
        .wb_dat_o(rdo), .wb_ack_o(ack), .refresh_i(refresh), .restart_i(restart),
        .unit_no_i(UNIT), .pv_i(pv), .alarm_i(alarm), .sensor_err_i(sens),
        .cont_act_o(cont), .init_act_o(init), .exp_act_o(expw), .io_base_o(io_base),
        .set_base_o(set_base), .setting_error_lamp_o(lamp), .irq_o(irq));
    host_refresh_model i_host (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .kick_i(kick),
        .refresh_o(refresh), .restart_o(restart), .pv_o(pv), .alarm_o(alarm),
        .sensor_o(sens));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) chk("ack", 16'h0000, 16'h0001);
        rdat = rdo[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        chk(nm, rdat, exp);
    endtask : rd_chk
    task automatic refresh_once;
        int n;
        n = 0;
        run <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (refresh !== 1'b1 && n < 20);
        run <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : refresh_once
    // Host holds three cycles, init takes two
    task automatic restart_unit;
        kick <= 1'b1;
        @(posedge clk_i);
        kick <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask : restart_unit
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, run, kick, adr, dat} = '0;
        error_cnt = 0;
        comparisons = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("io_base", io_base, IO_EXP);
        chk("set_base", set_base, SET_EXP);
        for (int k = 0; k < 4; k++) rd_chk("type", 8'h12 + 8'(2 * k), TDEF);
        rd_chk("cmd", 8'h00, 16'h0000);
        $display("power-on done");
        refresh_once();
        for (int k = 0; k < 4; k++) rd_chk("op_pv", 8'h80 + 8'(k), pv[16 * k +: 16]);
        rd_chk("op_alarm", 8'h84, alarm);
        rd_chk("op_sensor", 8'h85, {12'h000, sens});
        rd_chk("op_spare", 8'h89, 16'h0000);
        rd_chk("unmapped", 8'h40, 16'h0000);
        $display("operating words done");
        bus(1'b1, 8'h03, DMAX);
        refresh_once();
        chk("lamp", {15'h0, lamp}, 16'h0000);
        chk("cont_act", cont[31:16], DMAX);
        bus(1'b1, 8'h03, DMAX + 16'h0001);
        refresh_once();
        chk("lamp", {15'h0, lamp}, 16'h0001);
        rd_chk("err_addr", 8'h01, 16'h0003);
        bus(1'b1, 8'h03, DMAX);
        refresh_once();
        chk("lamp", {15'h0, lamp}, 16'h0000);
        $display("range done");
        bus(1'b1, 8'h14, 16'h0001);
        bus(1'b1, 8'h65, 16'h0002);
        refresh_once();
        chk("lamp", {15'h0, lamp}, 16'h0000);
        chk("init_act", init[47:32], TDEF);
        chk("exp_act", expw[31:16], 16'h0000);
        restart_unit();
        chk("lamp", {15'h0, lamp}, 16'h0001);
        rd_chk("err_addr", 8'h01, 16'h0014);
        bus(1'b1, 8'h14, 16'h0030);
        restart_unit();
        rd_chk("err_addr", 8'h01, 16'h0065);
        chk("init_act", init[47:32], 16'h0030);
        chk("init_ch0", init[15:0], TDEF);
        bus(1'b1, 8'h65, setting_area_pkg::EXP_MAX);
        restart_unit();
        chk("lamp", {15'h0, lamp}, 16'h0000);
        chk("exp_act", expw[31:16], setting_area_pkg::EXP_MAX);
        $display("restart done");
        rd_chk("status", 8'h8c, 16'h0007);
        bus(1'b1, 8'h8d, 16'h0007);
        bus(1'b1, 8'h8e, 16'h0000);
        rd_chk("status", 8'h8c, 16'h0000);
        refresh_once();
        chk("irq", {15'h0, irq}, 16'h0000);
        bus(1'b1, 8'h8c, 16'h0000);
        rd_chk("status", 8'h8c, 16'h0002);
        bus(1'b1, 8'h8e, 16'h0002);
        chk("irq", {15'h0, irq}, 16'h0001);
        rd_chk("enable", 8'h8e, 16'h0002);
        bus(1'b1, 8'h8d, 16'h0002);
        chk("irq", {15'h0, irq}, 16'h0000);
        rd_chk("status", 8'h8c, 16'h0000);
        $display("interrupt done");
        bus(1'b1, 8'h00, setting_area_pkg::DEFAULT_CMD);
        bus(1'b1, 8'h12, 16'h0000);
        restart_unit();
        rd_chk("cmd", 8'h00, 16'h0000);
        rd_chk("type_def", 8'h12, TDEF);
        rd_chk("cont_def", 8'h03, setting_area_pkg::CONT_DEFAULT);
        $display("default read done");
        report_and_stop();
    end
endmodule : setting_area_exchange_test
